// >>> logic/eaw_pkg.sv
// Constants, types and field layout of the angle timer and waveform control block
// How it works
// - Soft start aborts and restarts any calculation
// - Busy flag readable in calc start register
// - Sync start on timer finish or angle write
// - Select bit picks angle interrupt source
// - Direction bit makes angle count up or down
// - Order bit swaps V and W phase offsets
// - Two-bit clock select, changeable while running
// - Bit selects two-phase or three-phase waveform
// - Auto transfer loads results into compare registers
// - Calculations only while enabled; results readable
// - Timer enable runs; clear stops and zeroes
// - Angle wraps after 383 back to zero
// - Each calculation lasts thirty-five machine cycles
// - Compare writes ignored while auto transfer on
package eaw_pkg;
    localparam int ADR_W = 8;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } eaw_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } eaw_wb_rsp_t;

    typedef struct packed {
        logic [15:0] u;
        logic [15:0] v;
        logic [15:0] w;
    } eaw_cmp_t;

    // Register byte offsets
    localparam logic [ADR_W-1:0] OFS_CALC   = 8'h00;
    localparam logic [ADR_W-1:0] OFS_TMR    = 8'h04;
    localparam logic [ADR_W-1:0] OFS_ANGLE  = 8'h08;
    localparam logic [ADR_W-1:0] OFS_PERIOD = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_PHASE_U_COMPARE   = 8'h10;
    localparam logic [ADR_W-1:0] OFS_CMPV   = 8'h14;
    localparam logic [ADR_W-1:0] OFS_CMPW   = 8'h18;
    localparam logic [ADR_W-1:0] OFS_STAT   = 8'h1C;
    localparam logic [ADR_W-1:0] OFS_MASK   = 8'h20;

    // calc_start_control bits
    localparam int CS_SOFT = 3;
    localparam int CS_BUSY = 2;
    localparam int CS_SYNC = 1;
    localparam int CS_ISEL = 0;
    // angle_timer_control bits
    localparam int TC_DIR   = 7;
    localparam int TC_ORDER = 6;
    localparam int TC_CK_HI = 5;
    localparam int TC_CK_LO = 4;
    localparam int TC_3PH   = 3;
    localparam int TC_XFER  = 2;
    localparam int TC_CALC  = 1;
    localparam int TC_TEN   = 0;
    // Interrupt status and mask bits
    localparam int IRQ_ANGLE = 0;
    localparam int IRQ_DONE  = 1;
    localparam int IRQ_W     = 2;

    localparam logic [7:0]  CS_RST     = 8'h00;
    localparam logic [7:0]  TC_RST     = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'h0010;

    localparam int         ANGLE_W   = 9;
    localparam logic [8:0] ANGLE_MAX = 9'h17F;
    localparam logic [8:0] PH_120    = 9'h080;
    localparam logic [8:0] PH_240    = 9'h100;
    localparam logic [9:0] ANGLE_REV = 10'h180;

    localparam int          PER_W    = 12;
    localparam logic [11:0] PER_MIN  = 12'h010;
    localparam int          CORR_LSB = 12;

    localparam int CLK_PERIOD_NS  = 50;
    localparam int MACHINE_CYCLES = 35;
    localparam int CALC_TIME_NS   = 7000;
    localparam int CALC_CLKS      = (CALC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] CALC_LAST = 8'(CALC_CLKS - 1);
endpackage

// >>> logic/eaw_ctrl.sv
// Electrical angle timer, waveform calculation sequencer and Wishbone register file
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ns
module eaw_ctrl (
    // Clock and reset
    input  wire logic                 i_clk,
    input  wire logic                 i_rst_b,
    // Wishbone classic slave
    input  wire eaw_pkg::eaw_wb_req_t i_wb,
    output eaw_pkg::eaw_wb_rsp_t      o_wb,
    // PWM generator side
    output eaw_pkg::eaw_cmp_t         o_cmp,
    output logic                      o_cmp_load,
    output logic [8:0]                o_angle,
    // Interrupt
    output logic                      o_irq
);
    import eaw_pkg::*;

    logic                 ack_q;
    logic [31:0]          rd_q;
    logic [7:0]           cs_q;
    logic [7:0]           tc_q;
    logic [15:0]          per_q;
    logic [ANGLE_W-1:0]   angle_q;
    logic [ANGLE_W-1:0]   angle_d;
    logic [ANGLE_W-1:0]   snap_q;
    logic [ANGLE_W-1:0]   angle_wdat;
    logic [2:0]           pre_q;
    logic [PER_W-1:0]     per_cnt_q;
    logic [PER_W-1:0]     per_lim;
    logic [3:0]           slot_q;
    logic [7:0]           calc_cnt_q;
    logic                 busy_q;
    logic                 load_q;
    eaw_cmp_t             cmp_q;
    eaw_cmp_t             res_q;
    eaw_cmp_t             res_d;
    logic [IRQ_W-1:0]     stat_q;
    logic [IRQ_W-1:0]     mask_q;
    logic [IRQ_W-1:0]     stat_set;
    logic [IRQ_W-1:0]     stat_clr;
    logic                 first;
    logic                 wr_go;
    logic                 rd_go;
    logic                 tick;
    logic                 tmr_fin;
    logic                 soft_go;
    logic                 angle_wr;
    logic                 start_go;
    logic                 calc_done;
    logic                 calc_en;
    logic                 xfer_en;
    logic                 ten;
    logic [31:0]          rd_mux;

    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
        return adr == ofs;
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic en);
        return en ? new_v : old_v;
    endfunction

    // Phase offset modulo one revolution
    function automatic logic [ANGLE_W-1:0] padd(input logic [ANGLE_W-1:0] a,
                                                input logic [ANGLE_W-1:0] b);
        logic [9:0] s;
        s = {1'b0, a} + {1'b0, b};
        if (s >= ANGLE_REV) begin
            s = s - ANGLE_REV;
        end
        return s[ANGLE_W-1:0];
    endfunction

    function automatic logic [2:0] div_mask(input logic [1:0] ck);
        unique case (ck)
            2'h0: return 3'h0;
            2'h1: return 3'h1;
            2'h2: return 3'h3;
            2'h3: return 3'h7;
        endcase
    endfunction

    assign calc_en = tc_q[TC_CALC];
    assign xfer_en = tc_q[TC_XFER];
    assign ten     = tc_q[TC_TEN];

    // Bus: request seen at first edge, acted on at the ack edge
    assign first = i_wb.cyc & i_wb.stb & ~ack_q;
    assign wr_go = i_wb.cyc & i_wb.stb & i_wb.we & ack_q;
    assign rd_go = i_wb.cyc & i_wb.stb & ~i_wb.we & ack_q;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= first;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (i_wb.adr)
            OFS_CALC:   rd_mux = {24'h00_0000, 4'h0, 1'b0, busy_q, cs_q[CS_SYNC:CS_ISEL]};
            OFS_TMR:    rd_mux = {24'h00_0000, tc_q};
            OFS_ANGLE:  rd_mux = {23'h00_0000, angle_q};
            OFS_PERIOD: rd_mux = {16'h0000, per_q};
            OFS_PHASE_U_COMPARE:   rd_mux = {16'h0000, calc_en ? res_q.u : cmp_q.u};
            OFS_CMPV:   rd_mux = {16'h0000, calc_en ? res_q.v : cmp_q.v};
            OFS_CMPW:   rd_mux = {16'h0000, calc_en ? res_q.w : cmp_q.w};
            OFS_STAT:   rd_mux = {30'h0000_0000, stat_q};
            OFS_MASK:   rd_mux = {30'h0000_0000, mask_q};
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_q <= 32'h0000_0000;
        end else if (first) begin
            rd_q <= rd_mux;
        end
    end

    assign o_wb = '{ack: ack_q, dat: rd_q};

    // Control registers; the start bit is a strobe and is never stored
    assign soft_go = wr_go & hit(i_wb.adr, OFS_CALC) & i_wb.sel[0] & i_wb.dat[CS_SOFT];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cs_q   <= CS_RST;
            tc_q   <= TC_RST;
            per_q  <= PERIOD_RST;
            mask_q <= '0;
        end else if (wr_go) begin
            if (hit(i_wb.adr, OFS_CALC)) begin
                cs_q <= merge8(cs_q, {6'h00, i_wb.dat[CS_SYNC:CS_ISEL]}, i_wb.sel[0]);
            end
            if (hit(i_wb.adr, OFS_TMR)) begin
                tc_q <= merge8(tc_q, i_wb.dat[7:0], i_wb.sel[0]);
            end
            if (hit(i_wb.adr, OFS_PERIOD)) begin
                per_q[7:0]  <= merge8(per_q[7:0], i_wb.dat[7:0], i_wb.sel[0]);
                per_q[15:8] <= merge8(per_q[15:8], i_wb.dat[15:8], i_wb.sel[1]);
            end
            if (hit(i_wb.adr, OFS_MASK) && i_wb.sel[0]) begin
                mask_q <= i_wb.dat[IRQ_W-1:0];
            end
        end
    end

    // Timer clock: enable every 1, 2, 4 or 8 system clocks
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pre_q <= 3'h0;
        end else if (!ten) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end

    // Mask test lets the select change mid-run without a stall
    assign tick = ten & ((pre_q & div_mask(tc_q[TC_CK_HI:TC_CK_LO])) ==
                         div_mask(tc_q[TC_CK_HI:TC_CK_LO]));

    // Period m, stretched to m+1 in the first n of every 16 steps
    assign per_lim = ((per_q[PER_W-1:0] < PER_MIN) ? PER_MIN : per_q[PER_W-1:0])
                     - 12'h001 + {11'h000, (slot_q < per_q[15:CORR_LSB])};
    assign tmr_fin = tick & (per_cnt_q == per_lim);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            per_cnt_q <= '0;
            slot_q    <= 4'h0;
        end else if (!ten) begin
            per_cnt_q <= '0;
            slot_q    <= 4'h0;
        end else if (tmr_fin) begin
            per_cnt_q <= '0;
            slot_q    <= slot_q + 4'h1;
        end else if (tick) begin
            per_cnt_q <= per_cnt_q + 12'h001;
        end
    end

    assign angle_wdat = {i_wb.sel[1] ? i_wb.dat[8] : angle_q[8],
                         i_wb.sel[0] ? i_wb.dat[7:0] : angle_q[7:0]};
    // Values beyond one revolution are refused
    assign angle_wr = wr_go & hit(i_wb.adr, OFS_ANGLE) & (angle_wdat <= ANGLE_MAX);

    always_comb begin
        angle_d = angle_q;
        if (!ten) begin
            angle_d = '0;
        end else if (angle_wr) begin
            angle_d = angle_wdat;
        end else if (tmr_fin) begin
            if (tc_q[TC_DIR]) begin
                angle_d = (angle_q == ANGLE_MAX) ? '0 : angle_q + 9'h001;
            end else begin
                angle_d = (angle_q == '0) ? ANGLE_MAX : angle_q - 9'h001;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            angle_q <= '0;
        end else begin
            angle_q <= angle_d;
        end
    end

    assign o_angle = angle_q;

    // Calculation sequencer
    assign start_go  = calc_en & (soft_go | (cs_q[CS_SYNC] & (tmr_fin | angle_wr)));
    assign calc_done = calc_en & busy_q & (calc_cnt_q == CALC_LAST) & ~start_go;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_q     <= 1'b0;
            calc_cnt_q <= 8'h00;
            snap_q     <= '0;
        end else if (!calc_en) begin
            busy_q     <= 1'b0;
            calc_cnt_q <= 8'h00;
        end else if (start_go) begin
            busy_q     <= 1'b1;
            calc_cnt_q <= 8'h00;
            snap_q     <= angle_d;
        end else if (calc_done) begin
            busy_q     <= 1'b0;
        end else if (busy_q) begin
            calc_cnt_q <= calc_cnt_q + 8'h01;
        end
    end

    // Table lookup is outside this block: result is the phase angle, minus the smallest of the three when TC_3PH is set
    always_comb begin
        logic [ANGLE_W-1:0] pu;
        logic [ANGLE_W-1:0] pv;
        logic [ANGLE_W-1:0] pw;
        logic [ANGLE_W-1:0] pmin;
        pu = snap_q;
        pv = padd(snap_q, tc_q[TC_ORDER] ? PH_240 : PH_120);
        pw = padd(snap_q, tc_q[TC_ORDER] ? PH_120 : PH_240);
        pmin = (pu < pv) ? pu : pv;
        pmin = (pw < pmin) ? pw : pmin;
        if (tc_q[TC_3PH]) begin
            pu = pu - pmin;
            pv = pv - pmin;
            pw = pw - pmin;
        end
        res_d = '{u: {7'h00, pu}, v: {7'h00, pv}, w: {7'h00, pw}};
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            res_q <= '0;
        end else if (calc_done) begin
            res_q <= res_d;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmp_q  <= '0;
            load_q <= 1'b0;
        end else if (calc_done && xfer_en) begin
            cmp_q  <= res_d;
            load_q <= 1'b1;
        end else if (wr_go && !xfer_en && i_wb.sel[1:0] == 2'h3 &&
                     (hit(i_wb.adr, OFS_PHASE_U_COMPARE) || hit(i_wb.adr, OFS_CMPV) ||
                      hit(i_wb.adr, OFS_CMPW))) begin
            if (hit(i_wb.adr, OFS_PHASE_U_COMPARE)) cmp_q.u <= i_wb.dat[15:0];
            if (hit(i_wb.adr, OFS_CMPV)) cmp_q.v <= i_wb.dat[15:0];
            if (hit(i_wb.adr, OFS_CMPW)) cmp_q.w <= i_wb.dat[15:0];
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
        end
    end

    assign o_cmp      = cmp_q;
    assign o_cmp_load = load_q;

    // Interrupts; only bits shown by the read are cleared, so a late event survives
    assign stat_set[IRQ_ANGLE] = cs_q[CS_ISEL] ? calc_done : tmr_fin;
    assign stat_set[IRQ_DONE]  = calc_done;
    assign stat_clr = (rd_go && hit(i_wb.adr, OFS_STAT)) ? rd_q[IRQ_W-1:0] : '0;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~stat_clr) | stat_set;
        end
    end

    assign o_irq = |(stat_q & mask_q);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    a_soft_restart: assert property (soft_go && calc_en |=> busy_q && calc_cnt_q == 8'h00)
        else $error("soft start did not restart calculation");
    a_busy_read: assert property (first && !i_wb.we && i_wb.adr == OFS_CALC
        |=> o_wb.ack && o_wb.dat[CS_BUSY] == $past(busy_q))
        else $error("busy flag read mismatch");
    a_sync_start: assert property (tmr_fin && cs_q[CS_SYNC] && calc_en
        |=> busy_q && calc_cnt_q == 8'h00)
        else $error("timer finish did not start calculation");
    a_no_sync_start: assert property (!busy_q && !soft_go && !cs_q[CS_SYNC] |=> !busy_q)
        else $error("calculation started without trigger");
    a_irq_source: assert property (tmr_fin && !cs_q[CS_ISEL] |=> stat_q[IRQ_ANGLE])
        else $error("angle interrupt not raised on timer finish");
    a_count_down: assert property (tmr_fin && ten && !tc_q[TC_DIR] && !angle_wr && angle_q != '0
        |=> angle_q == $past(angle_q) - 9'h001)
        else $error("down count step wrong");
    a_phase_order: assert property (calc_done && !tc_q[TC_3PH] && tc_q[TC_ORDER]
        |=> res_q.v[8:0] == padd(res_q.u[8:0], PH_240))
        else $error("reversed phase order wrong");
    a_clock_div: assert property (tick && tc_q[TC_CK_HI:TC_CK_LO] == 2'h3
        ##1 (ten && tc_q[TC_CK_HI:TC_CK_LO] == 2'h3) [*3]
        |-> !tick && !$past(tick) && !$past(tick, 2))
        else $error("divide by eight tick spacing wrong");
    a_three_phase: assert property (calc_done && tc_q[TC_3PH]
        |=> res_q.u == 16'h0000 || res_q.v == 16'h0000 || res_q.w == 16'h0000)
        else $error("three phase offset not removed");
    a_auto_xfer: assert property (calc_done && xfer_en
        |=> o_cmp == $past(res_d) && o_cmp_load)
        else $error("result not transferred");
    a_calc_off: assert property (!calc_en |=> !busy_q)
        else $error("busy while calculation disabled");
    a_timer_off: assert property (!ten |=> angle_q == '0 && per_cnt_q == '0)
        else $error("disabled timer not cleared");
    a_angle_wrap: assert property (tmr_fin && ten && tc_q[TC_DIR] && !angle_wr
        && angle_q == ANGLE_MAX |=> angle_q == '0)
        else $error("angle did not wrap");
    a_calc_time: assert property (start_go ##1 (busy_q && !start_go && calc_en) [*8]
        |-> calc_cnt_q == 8'h07)
        else $error("calculation counter rate wrong");
    a_calc_end: assert property (busy_q && calc_cnt_q == CALC_LAST && !start_go && calc_en
        |=> !busy_q)
        else $error("calculation did not end on time");
    a_cmp_locked: assert property (xfer_en && !calc_done |=> $stable(o_cmp))
        else $error("compare changed while transfer enabled");
    a_busy_rise: assert property ($rose(busy_q) |-> $past(start_go))
        else $error("busy rose without start");

    c_soft_start: cover property (soft_go && busy_q);
    c_auto_load: cover property (calc_done && xfer_en);
    c_angle_wrap: cover property (tmr_fin && angle_q == ANGLE_MAX);
    c_irq: cover property (o_irq);
endmodule // eaw_ctrl

// >>> test/eaw_pwm_model.sv
// PWM generator compare register stand-in, latching each load pulse
`timescale 1ns/1ns
module eaw_pwm_model (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    // From the control block
    input  wire eaw_pkg::eaw_cmp_t i_cmp,
    input  wire logic              i_load,
    // Duty values seen by the PWM counters
    output eaw_pkg::eaw_cmp_t      o_duty
);
    import eaw_pkg::*;

    // Only the load pulse qualifies the compare bus
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_duty <= '0;
        end else if (i_load) begin
            o_duty <= i_cmp;
        end
    end
endmodule // eaw_pwm_model

// >>> test/electrical_angle_waveform_ctrl_tb.sv
// Self-checking bench for the angle timer and waveform control block
`timescale 1ns/1ns
module electrical_angle_waveform_ctrl_tb;
    import eaw_pkg::*;

    logic        i_clk;
    logic        i_rst_b;
    eaw_wb_req_t wb_q;
    eaw_wb_rsp_t o_wb;
    eaw_cmp_t    o_cmp;
    eaw_cmp_t    duty;
    logic        o_cmp_load;
    logic [8:0]  o_angle;
    logic        o_irq;
    int          fails;
    int          checked;
    integer      seed;
    logic [31:0] rd;
    logic [31:0] r;
    int          n;
    int          a;
    eaw_cmp_t    exp_q[$];
    eaw_cmp_t    e;

    eaw_ctrl u_dut (
        .i_clk      (i_clk),
        .i_rst_b    (i_rst_b),
        .i_wb       (wb_q),
        .o_wb       (o_wb),
        .o_cmp      (o_cmp),
        .o_cmp_load (o_cmp_load),
        .o_angle    (o_angle),
        .o_irq      (o_irq)
    );

    eaw_pwm_model u_pwm (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_cmp   (o_cmp),
        .i_load  (o_cmp_load),
        .o_duty  (duty)
    );

    always #25 i_clk = ~i_clk;

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t %s seen %0h exp %0h", $time, what, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; the ack wait gives up after 100 clocks and fails a check
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      output logic [31:0] q);
        int k;
        k = 0;
        wb_q.cyc <= 1'b1;
        wb_q.stb <= 1'b1;
        wb_q.we  <= we;
        wb_q.adr <= adr;
        wb_q.sel <= 4'hF;
        wb_q.dat <= d;
        do begin
            @(posedge i_clk);
            k++;
        end while (o_wb.ack !== 1'b1 && k < 100);
        q = o_wb.dat;
        if (k >= 100) chk(48'h0, 48'h1, "no ack");
        wb_q.cyc <= 1'b0;
        wb_q.stb <= 1'b0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, adr, d, q);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp, input string what);
        wb(1'b0, adr, 32'h0, rd);
        chk(48'(rd), 48'(exp), what);
    endtask

    task automatic wait_load(input int lim, output int k);
        k = 0;
        while (o_cmp_load !== 1'b1 && k < lim) begin
            @(posedge i_clk);
            k++;
        end
    endtask

    task automatic wait_chg(output int k);
        logic [8:0] a0;
        a0 = o_angle;
        k = 0;
        while (o_angle === a0 && k < 2000) begin
            @(posedge i_clk);
            k++;
        end
    endtask

    // Phase angles per output; three-phase drops the common minimum
    function automatic eaw_cmp_t res(int ang, int ord, int th);
        int p[3];
        int m;
        p[0] = ang;
        p[1] = (ang + (ord != 0 ? 256 : 128)) % 384;
        p[2] = (ang + (ord != 0 ? 128 : 256)) % 384;
        m = p[0];
        if (p[1] < m) m = p[1];
        if (p[2] < m) m = p[2];
        if (th == 0) m = 0;
        res.u = 16'(p[0] - m);
        res.v = 16'(p[1] - m);
        res.w = 16'(p[2] - m);
    endfunction

    initial begin
        #(50 * 60000);
        fails++;
        stop_test();
    end

    initial begin
        i_clk   = 1'b0;
        i_rst_b = 1'b0;
        wb_q    = '0;
        seed    = 78510;
        fails   = 0;
        checked = 0;
        repeat (5) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        rdc(OFS_CALC, 32'h0, "calc rst");
        rdc(OFS_TMR, 32'h0, "tmr rst");
        rdc(OFS_PERIOD, 32'h10, "period rst");
        rdc(OFS_STAT, 32'h0, "stat rst");
        rdc(8'h40, 32'h0, "unmapped");
        chk(48'(o_angle), 48'h0, "angle rst");
        // Step spacing for every clock select, changed while running
        wr(OFS_TMR, 32'h81);
        for (int cs = 0; cs < 4; cs++) begin
            wr(OFS_TMR, 32'h81 | (cs << 4));
            wait_chg(n);
            a = o_angle;
            wait_chg(n);
            chk(48'(n), 48'(16 << cs), "step time");
            chk(48'(o_angle), 48'((a + 1) % 384), "count up");
        end
        wr(OFS_TMR, 32'h31);
        wr(OFS_ANGLE, 32'h0);
        wait_chg(n);
        chk(48'(o_angle), 48'd383, "down wrap");
        wr(OFS_TMR, 32'hB1);
        wr(OFS_ANGLE, 32'd383);
        wait_chg(n);
        chk(48'(o_angle), 48'h0, "up wrap");
        // Timer-finish interrupt
        wr(OFS_MASK, 32'h1);
        n = 0;
        while (o_irq !== 1'b1 && n < 300) begin
            @(posedge i_clk);
            n++;
        end
        chk(48'(o_irq), 48'h1, "irq tmr");
        wb(1'b0, OFS_STAT, 32'h0, rd);
        chk(48'(rd[IRQ_ANGLE]), 48'h1, "stat tmr");
        wr(OFS_TMR, 32'h0);
        wb(1'b0, OFS_STAT, 32'h0, rd);
        chk(48'(o_irq), 48'h0, "irq clr");
        chk(48'(o_angle), 48'h0, "stop zero");
        wr(OFS_MASK, 32'h0);
        // Long period keeps the angle still while results are predicted
        wr(OFS_PERIOD, 32'hFFF);
        rdc(OFS_PERIOD, 32'hFFF, "period wr");
        // Calculation disabled: soft start does nothing
        wr(OFS_TMR, 32'h1);
        wr(OFS_CALC, 32'h8);
        wait_load(160, n);
        chk(48'(n), 48'd160, "calc off");
        // Soft start, busy, abort and restart
        wr(OFS_TMR, 32'h37);
        wr(OFS_CALC, 32'h8);
        rdc(OFS_CALC, 32'h4, "busy");
        repeat (40) @(posedge i_clk);
        exp_q.push_back(res(int'(o_angle), 0, 0));
        wr(OFS_CALC, 32'h8);
        wait_load(300, n);
        chk(48'(n >= 138 && n <= 142), 48'h1, "calc time");
        repeat (2) @(posedge i_clk);
        chk(duty, exp_q.pop_front(), "soft result");
        rdc(OFS_CALC, 32'h0, "idle");
        wr(OFS_ANGLE, 32'd10);
        wait_load(160, n);
        chk(48'(n), 48'd160, "no sync");
        // Sync start on angle write, both orders, both modulations
        wr(OFS_MASK, 32'h2);
        wr(OFS_CALC, 32'h3);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_TMR, 32'hB7 | ((k & 1) << 6) | ((k >> 1) << 3));
            a = $unsigned($random(seed)) % 384;
            e = res(a, k & 1, k >> 1);
            exp_q.push_back(e);
            wr(OFS_ANGLE, 32'(a));
            wait_load(300, n);
            chk(48'(n < 300), 48'h1, "sync time");
            repeat (2) @(posedge i_clk);
            chk(duty, exp_q.pop_front(), "sync result");
            rdc(OFS_CMPV, 32'(e.v), "cmp read");
            chk(48'(o_irq), 48'h1, "irq calc");
            wb(1'b0, OFS_STAT, 32'h0, rd);
            chk(48'(rd[IRQ_DONE]), 48'h1, "stat calc");
            chk(48'(o_irq), 48'h0, "irq cleared");
        end
        // Software compare writes, accepted then locked out
        wr(OFS_TMR, 32'h1);
        r = $random(seed);
        wr(OFS_PHASE_U_COMPARE, r);
        rdc(OFS_PHASE_U_COMPARE, 32'(r[15:0]), "cmp wr");
        chk(48'(duty.u), 48'(r[15:0]), "cmp load");
        wr(OFS_TMR, 32'h5);
        wr(OFS_PHASE_U_COMPARE, ~r);
        rdc(OFS_PHASE_U_COMPARE, 32'(r[15:0]), "cmp locked");
        stop_test();
    end
endmodule // electrical_angle_waveform_ctrl_tb
